// ---- core/rcr_pkg.sv ----
// Package with register map, field layout, reset values and timing for the reset cause recorder
package rcr_pkg;

    // Register byte addresses on the APB bus
    localparam logic [31:0] RCR_CAUSE_OFS    = 32'h00ffe050;
    localparam logic [31:0] RCR_IRQ_STAT_OFS = 32'h00ffe054;
    localparam logic [31:0] RCR_IRQ_MASK_OFS = 32'h00ffe058;

    // Field positions in the cause register
    localparam int RCR_POR_BIT   = 7;
    localparam int RCR_STOP_BIT  = 6;
    localparam int RCR_WDOG_BIT  = 5;
    localparam int RCR_EXT_BIT   = 4;
    localparam int RCR_FAULT_BIT = 3;
    localparam int RCR_SW_BIT    = 2;
    localparam int RCR_RSVD_BIT  = 1;
    localparam int RCR_SWRST_BIT = 0;

    // Cause field is bits 7:2, six flags wide
    localparam int RCR_FLAG_LSB = 2;
    localparam int RCR_NFLAGS   = 6;
    localparam int RCR_NSRC     = 5;

    // Reset values
    localparam logic [5:0] RCR_FLAGS_RST = 6'h20;
    localparam logic [5:0] RCR_STAT_RST  = 6'h00;
    localparam logic [5:0] RCR_MASK_RST  = 6'h00;

    // Length of the system reset request pulse
    localparam int RCR_CLK_PERIOD_PS = 5000;
    localparam int RCR_RST_PULSE_NS  = 100;
    localparam int RCR_RST_PULSE_CYC =
        (RCR_RST_PULSE_NS * 1000 + RCR_CLK_PERIOD_PS - 1) / RCR_CLK_PERIOD_PS;

    // Register selector
    typedef enum logic [1:0]
    {
        REG_CAUSE = 2'b00,
        REG_STAT  = 2'b01,
        REG_MASK  = 2'b10,
        REG_NONE  = 2'b11
    } rcr_reg_t;

    // Word address decode, low two address bits ignored
    function automatic rcr_reg_t rcr_decode(input logic [31:0] addr);
        rcr_reg_t sel;
        sel = REG_NONE;
        if (addr[31:2] == RCR_CAUSE_OFS[31:2])
            sel = REG_CAUSE;
        else if (addr[31:2] == RCR_IRQ_STAT_OFS[31:2])
            sel = REG_STAT;
        else if (addr[31:2] == RCR_IRQ_MASK_OFS[31:2])
            sel = REG_MASK;
        return sel;
    endfunction

endpackage

// ---- core/rcr_reg_if.sv ----
// Interface between the APB slave and the register core
`timescale 1ns/1ps
interface rcr_reg_if;
    import rcr_pkg::*;

    rcr_reg_t   idx;      // Selected register
    logic       acc_wr;   // Write completes this cycle
    logic       acc_rd;   // Read completes this cycle
    logic [7:0] wdata;    // Write data, low byte
    logic [7:0] rdata;    // Live read value from core
    logic [7:0] rd_snap;  // Value returned to the master

    modport bus
    (
        output idx,
        output acc_wr,
        output acc_rd,
        output wdata,
        output rd_snap,
        input  rdata
    );

    modport core
    (
        input  idx,
        input  acc_wr,
        input  acc_rd,
        input  wdata,
        input  rd_snap,
        output rdata
    );
endinterface

// ---- core/rcr_src_sync.sv ----
// Two-stage synchronisers and rising-edge detectors for the reset source inputs
`timescale 1ns/1ps
module rcr_src_sync
#(
    parameter int N = 5
)
(
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    // Source levels and event pulses
    input  wire logic [N-1:0] i_lvl,
    output logic      [N-1:0] o_rise
);

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_src
            logic meta_ff;
            logic sync_ff;
            logic prev_ff;
            logic rise_ff;
            logic nxt_rise;

            // Edge of the synchronised level
            always_comb
            begin
                nxt_rise = sync_ff & ~prev_ff;
            end

            // Synchroniser chain and pulse register
            always_ff @(posedge i_clk)
            begin
                if (i_sys_rst)
                begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    prev_ff <= 1'b0;
                    rise_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= i_lvl[g];
                    sync_ff <= meta_ff;
                    prev_ff <= sync_ff;
                    rise_ff <= nxt_rise;
                end
            end

            assign o_rise[g] = rise_ff;
        end
    endgenerate

endmodule

// ---- core/rcr_apb_slave.sv ----
// APB slave front end: decode, read data capture and access strobes
`timescale 1ns/1ps
module rcr_apb_slave
    import rcr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // APB
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Register core side
    rcr_reg_if.bus           reg_if
);

    logic [7:0] prdata_ff;
    logic [7:0] nxt_prdata;
    logic       setup;
    logic       access;
    rcr_reg_t   sel;

    // Phase decode and strobes
    always_comb
    begin
        setup         = i_psel & ~i_penable;
        access        = i_psel & i_penable;
        sel           = rcr_decode(i_paddr);
        reg_if.idx    = sel;
        reg_if.wdata  = i_pwdata[7:0];
        reg_if.acc_wr = access & i_pwrite & i_pstrb[0] & (sel != REG_NONE);
        reg_if.acc_rd = access & ~i_pwrite & (sel != REG_NONE);
        o_pready      = 1'b1;                          // Zero wait states
        o_pslverr     = access & (sel == REG_NONE);
        nxt_prdata    = prdata_ff;
        if (setup)
            nxt_prdata = i_pwrite ? 8'h00 : reg_if.rdata;  // Writes capture zero; reads capture the live register value
    end

    // Read data captured in the setup cycle
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            prdata_ff <= 8'h00;
        else
            prdata_ff <= nxt_prdata;
    end

    assign o_prdata       = {24'h000000, prdata_ff};
    assign reg_if.rd_snap = prdata_ff;

endmodule

// ---- core/rcr_top.sv ----
// Reset cause recorder: cause register, software reset request and cause interrupt
`timescale 1ns/1ps
// Function
// - Keep a readable register naming the source of the latest reset or recovery.
// - Every reset or recovery event rewrites all cause flags together.
// - Read-only flags in bits 7:2: power-on, stop, watchdog, pin, fault, software.
// - Writing 1 to bit 0 starts a system reset; writing 0 does nothing.
// - A software-started reset sets the software cause flag, bit 2.
module rcr_top
    import rcr_pkg::*;
#(
    parameter int RST_PULSE_CYC = RCR_RST_PULSE_CYC
)
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // APB
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Reset sources, asynchronous levels
    input  wire logic        i_por_src,
    input  wire logic        i_stop_rec_src,
    input  wire logic        i_watchdog_src,
    input  wire logic        i_ext_pin_src,
    input  wire logic        i_fault_src,
    // System outputs
    output logic             o_sys_rst_req,
    output logic             o_irq
);

    localparam int CW = $clog2(RST_PULSE_CYC + 1);

    // Reset request states
    typedef enum logic [0:0]
    {
        REQ_IDLE = 1'b0,    // No request standing
        REQ_HOLD = 1'b1     // Request standing, count running
    } rcr_req_st_t;

    rcr_reg_if reg_if ();

    logic [RCR_NSRC-1:0]   src_rise;
    logic [RCR_NFLAGS-1:0] evt;
    logic                  sw_evt;
    logic [RCR_NFLAGS-1:0] flags_ff;
    logic [RCR_NFLAGS-1:0] nxt_flags;
    logic [RCR_NFLAGS-1:0] stat_ff;
    logic [RCR_NFLAGS-1:0] nxt_stat;
    logic [RCR_NFLAGS-1:0] mask_ff;
    logic [RCR_NFLAGS-1:0] nxt_mask;
    logic [RCR_NFLAGS-1:0] stat_clr;
    logic [CW-1:0]         cnt_ff;
    logic [CW-1:0]         nxt_cnt;
    logic                  irq_ff;
    logic                  nxt_irq;
    // Reset request state and per-register access strobes
    rcr_req_st_t           req_st_ff;
    rcr_req_st_t           nxt_req_st;
    logic                  wr_cause;
    logic                  wr_mask;
    logic                  rd_stat;
    // Read words in register layout
    logic [7:0]            cause_word;
    logic [7:0]            stat_word;
    logic [7:0]            mask_word;

    // Bus front end
    rcr_apb_slave u_apb
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_pwrite  (i_pwrite),
        .i_paddr   (i_paddr),
        .i_pwdata  (i_pwdata),
        .i_pstrb   (i_pstrb),
        .o_prdata  (o_prdata),
        .o_pready  (o_pready),
        .o_pslverr (o_pslverr),
        .reg_if    (reg_if.bus)
    );

    // Source synchronisers, order matches flag bits 7 down to 3
    rcr_src_sync #(.N(RCR_NSRC)) u_sync
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_lvl     ({i_por_src, i_stop_rec_src, i_watchdog_src, i_ext_pin_src, i_fault_src}),
        .o_rise    (src_rise)
    );

    // Strobe for one register; every side effect of an access uses it
    // Keeps the write, read and register match in one place
    function automatic logic reg_hit
    (
        input logic     strobe,
        input rcr_reg_t idx,
        input rcr_reg_t want
    );
        return strobe && (idx == want);
    endfunction

    // Status and mask words: flags in bits 5:0, top two bits read zero
    function automatic logic [7:0] flag_word
    (
        input logic [RCR_NFLAGS-1:0] flags
    );
        return {2'h0, flags};
    endfunction

    // Access strobes, one per register side effect
    // Unmapped addresses never match, so they have no effect here
    always_comb
    begin
        wr_cause = reg_hit(reg_if.acc_wr, reg_if.idx, REG_CAUSE);
        wr_mask  = reg_hit(reg_if.acc_wr, reg_if.idx, REG_MASK);
        rd_stat  = reg_hit(reg_if.acc_rd, reg_if.idx, REG_STAT);
    end

    // Software reset: only bit 0 acts, bits 7:1 are ignored on write
    // A write of 0 to bit 0 is a plain no-op, so read-modify-write is harmless
    always_comb
    begin
        sw_evt = wr_cause & reg_if.wdata[RCR_SWRST_BIT];
    end

    // Event vector in flag order, positions taken from the field map
    // Sources arrive in synchroniser order: power-on first, fault last
    always_comb
    begin
        evt                               = '0;
        evt[RCR_POR_BIT   - RCR_FLAG_LSB] = src_rise[4];
        evt[RCR_STOP_BIT  - RCR_FLAG_LSB] = src_rise[3];
        evt[RCR_WDOG_BIT  - RCR_FLAG_LSB] = src_rise[2];
        evt[RCR_EXT_BIT   - RCR_FLAG_LSB] = src_rise[1];
        evt[RCR_FAULT_BIT - RCR_FLAG_LSB] = src_rise[0];
        evt[RCR_SW_BIT    - RCR_FLAG_LSB] = sw_evt;
    end

    // Cause flags: whole field rewritten on any event
    // Old causes are dropped, so the register names only the latest event
    always_comb
    begin
        nxt_flags = flags_ff;
        if (|evt)
            nxt_flags = evt;
    end

    // Cause flag register; power-on cause reported after reset
    // The reset that clears this block is itself reported as power-on
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            flags_ff <= RCR_FLAGS_RST;
        else
            flags_ff <= nxt_flags;
    end

    // Read clear: only bits returned in the setup snapshot are cleared
    // A bit that sets after the snapshot stays set for the next read
    always_comb
    begin
        stat_clr = '0;
        if (rd_stat)
            stat_clr = reg_if.rd_snap[RCR_NFLAGS-1:0];
    end

    // Loop index shared by the per-flag generate loops
    genvar g;

    // Sticky status bits; a new event beats a clear in the same cycle
    generate
        for (g = 0; g < RCR_NFLAGS; g++)
        begin : g_stat
            assign nxt_stat[g] = (stat_ff[g] & ~stat_clr[g]) | evt[g];
        end
    endgenerate

    // Mask write and interrupt level
    // The level uses next values so it moves in step with the status
    // Masking a set bit drops the level without losing the status
    always_comb
    begin
        nxt_mask = mask_ff;
        if (wr_mask)
            nxt_mask = reg_if.wdata[RCR_NFLAGS-1:0];
        nxt_irq = |(nxt_stat & nxt_mask);
    end

    // Interrupt status, mask and output level
    // Status clears only by read; reset starts it empty
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            stat_ff <= RCR_STAT_RST;
            mask_ff <= RCR_MASK_RST;
            irq_ff  <= 1'b0;
        end
        else
        begin
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff  <= nxt_irq;
        end
    end

    // System reset request: held for a fixed count after each trigger
    // A new trigger while the request stands restarts the count
    always_comb
    begin
        nxt_req_st = req_st_ff;
        nxt_cnt    = cnt_ff;
        case (req_st_ff)
            REQ_IDLE:
            begin
                if (sw_evt)
                begin
                    nxt_req_st = REQ_HOLD;
                    nxt_cnt    = CW'(RST_PULSE_CYC);
                end
            end
            REQ_HOLD:
            begin
                if (sw_evt)
                    nxt_cnt = CW'(RST_PULSE_CYC);
                else if (cnt_ff == CW'(1))
                begin
                    nxt_req_st = REQ_IDLE;
                    nxt_cnt    = '0;
                end
                else
                    nxt_cnt = cnt_ff - CW'(1);
            end
            default:
            begin
                nxt_req_st = REQ_IDLE;
                nxt_cnt    = '0;
            end
        endcase
    end

    // Reset request state and counter
    // The request does not clear this block; only the system reset does
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            req_st_ff <= REQ_IDLE;
            cnt_ff    <= '0;
        end
        else
        begin
            req_st_ff <= nxt_req_st;
            cnt_ff    <= nxt_cnt;
        end
    end

    // Cause word: flag i sits at bit RCR_FLAG_LSB+i
    // Reserved bit 1 and write-only bit 0 always read zero
    generate
        for (g = 0; g < RCR_NFLAGS; g++)
        begin : g_cause
            assign cause_word[RCR_FLAG_LSB+g] = flags_ff[g];
        end
    endgenerate
    assign cause_word[RCR_RSVD_BIT]  = 1'b0;
    assign cause_word[RCR_SWRST_BIT] = 1'b0;

    // Status and mask words share the flag layout
    // Bit i of either word matches cause flag bit i+2
    assign stat_word = flag_word(stat_ff);
    assign mask_word = flag_word(mask_ff);

    // Read mux
    // Unmapped addresses read zero
    always_comb
    begin
        case (reg_if.idx)
            REG_CAUSE: reg_if.rdata = cause_word;
            REG_STAT:  reg_if.rdata = stat_word;
            REG_MASK:  reg_if.rdata = mask_word;
            default:   reg_if.rdata = 8'h00;
        endcase
    end

    // Both outputs come straight from flip-flops
    assign o_sys_rst_req = (req_st_ff == REQ_HOLD);
    assign o_irq         = irq_ff;

endmodule

// ---- sim/rcr_monitor.sv ----
// Port checker for the reset cause recorder
`timescale 1ns/1ps
module rcr_monitor
    import rcr_pkg::*;
#(
    parameter int RST_PULSE_CYC = RCR_RST_PULSE_CYC
)
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // System outputs
    input wire logic        o_sys_rst_req,
    input wire logic        o_irq
);
    logic        acc;
    logic        sw_wr;
    logic        mapped;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;

    // Access phase decode
    assign acc    = i_psel && i_penable;
    assign sw_wr  = acc && i_pwrite && i_pstrb[0] && i_pwdata[0]
                    && i_paddr[31:2] == RCR_CAUSE_OFS[31:2];
    assign mapped = i_paddr[31:2] == RCR_CAUSE_OFS[31:2]
                    || i_paddr[31:2] == RCR_IRQ_STAT_OFS[31:2]
                    || i_paddr[31:2] == RCR_IRQ_MASK_OFS[31:2];

    // Cycles the request has stood since its last start
    always_comb nxt_cnt = sw_wr ? 32'h0 : (o_sys_rst_req ? cnt_ff + 32'h1 : 32'h0);
    always_ff @(posedge i_clk) cnt_ff <= i_sys_rst ? 32'h0 : nxt_cnt;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_sw_wr;
        sw_wr;
    endsequence
    sequence s_mask_off;
        acc && i_pwrite && i_pstrb[0] && i_pwdata[5:0] == 6'h00
        && i_paddr[31:2] == RCR_IRQ_MASK_OFS[31:2];
    endsequence

    property p_ready;
        o_pready;
    endproperty
    property p_req_start;
        s_sw_wr |=> o_sys_rst_req;
    endproperty
    property p_req_cause;
        $rose(o_sys_rst_req) |-> $past(sw_wr);
    endproperty
    property p_req_len;
        $fell(o_sys_rst_req) |-> cnt_ff == RST_PULSE_CYC;
    endproperty
    property p_rd_bits;
        acc && !i_pwrite && i_paddr == RCR_CAUSE_OFS |-> o_prdata[1:0] == 2'h0
            && o_prdata[31:8] == 24'h0;
    endproperty
    property p_slverr;
        acc |-> o_pslverr == !mapped;
    endproperty
    property p_irq_off;
        s_mask_off |-> ##[1:2] !o_irq;
    endproperty
    property p_rd_hold;
        !(i_psel && !i_penable) |=> $stable(o_prdata);
    endproperty

    a_ready: assert property (p_ready) else $error("pready low");
    a_req_start: assert property (p_req_start) else $error("request not raised");
    a_req_cause: assert property (p_req_cause) else $error("request without write");
    a_req_len: assert property (p_req_len) else $error("request length wrong");
    a_rd_bits: assert property (p_rd_bits) else $error("cause read bits wrong");
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    a_irq_off: assert property (p_irq_off) else $error("irq not masked");
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
endmodule

bind rcr_top rcr_monitor #(.RST_PULSE_CYC(RST_PULSE_CYC)) rcr_monitor_i (.*);

// ---- sim/testbench.sv ----
// Self-checking bench for the reset cause recorder
`timescale 1ns/1ps
module testbench
    import rcr_pkg::*;
;
    localparam int PC = 4;
    logic        i_clk, i_sys_rst, i_psel, i_penable, i_pwrite, er;
    logic [31:0] i_paddr, i_pwdata, o_prdata, rd;
    logic [3:0]  i_pstrb;
    logic        o_pready, o_pslverr, o_sys_rst_req, o_irq;
    logic [4:0]  src;
    int          n_errors, n_tests, n;

    // Device under test, sources por, stop, watchdog, pin, fault
    rcr_top #(.RST_PULSE_CYC(PC)) rcr_top_i (.*, .i_por_src(src[4]), .i_stop_rec_src(src[3]),
        .i_watchdog_src(src[2]), .i_ext_pin_src(src[1]), .i_fault_src(src[0]));

    // Clock
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge i_clk);
            if (o_pready === 1'b1)
                break;
        end
        if (n == 50)
            chk("pready", 1, 0);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(nm, exp, rd);
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge i_clk);
        src <= v;
        repeat (6) @(posedge i_clk);
        src <= 5'h00;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic t_sources;
        rdc(RCR_CAUSE_OFS, 32'h80, "cause reset");
        rdc(RCR_IRQ_MASK_OFS, 32'h0, "mask reset");
        for (int k = 0; k < 5; k++)
        begin
            pulse(5'h10 >> k);
            rdc(RCR_CAUSE_OFS, 32'h80 >> k, "cause one");
        end
        pulse(5'h05);
        rdc(RCR_CAUSE_OFS, 32'h28, "cause two");
    endtask

    task automatic t_swrst;
        apb(1'b1, RCR_CAUSE_OFS, 32'h00, 4'h1);
        apb(1'b1, RCR_CAUSE_OFS, 32'h01, 4'h0);
        @(posedge i_clk);
        chk("req idle", 0, o_sys_rst_req);
        rdc(RCR_CAUSE_OFS, 32'h28, "cause kept");
        apb(1'b1, RCR_CAUSE_OFS, 32'h01, 4'h1);
        for (n = 0; n < 100; n++)
        begin
            @(posedge i_clk);
            if (o_sys_rst_req !== 1'b1)
                break;
        end
        chk("req length", PC, n);
        rdc(RCR_CAUSE_OFS, 32'h04, "cause sw");
    endtask

    task automatic t_irq;
        rdc(RCR_IRQ_STAT_OFS, 32'h3f, "stat all");
        apb(1'b1, RCR_IRQ_MASK_OFS, 32'h04, 4'h1);
        rdc(RCR_IRQ_MASK_OFS, 32'h04, "mask");
        pulse(5'h01);
        chk("irq masked", 0, o_irq);
        pulse(5'h02);
        chk("irq", 1, o_irq);
        apb(1'b1, RCR_IRQ_MASK_OFS, 32'h00, 4'h1);
        repeat (3) @(posedge i_clk);
        chk("irq off", 0, o_irq);
        rdc(RCR_IRQ_STAT_OFS, 32'h06, "stat");
        rdc(RCR_IRQ_STAT_OFS, 32'h00, "stat clear");
    endtask

    task automatic t_unmapped;
        apb(1'b1, 32'h00ffe05c, 32'h01, 4'h1);
        chk("wr err", 1, er);
        rdc(32'h00ffe05c, 32'h0, "unmapped");
        chk("rd err", 1, er);
        chk("req", 0, o_sys_rst_req);
    endtask

    // Reset in mid-request drops the request and restores power-on state
    task automatic t_rerst;
        apb(1'b1, RCR_CAUSE_OFS, 32'h01, 4'h1);
        @(posedge i_clk);
        chk("req up", 1, o_sys_rst_req);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        chk("req reset", 0, o_sys_rst_req);
        rdc(RCR_CAUSE_OFS, 32'h80, "cause rerst");
        rdc(RCR_IRQ_STAT_OFS, 32'h0, "stat rerst");
    endtask

    // Main sequence
    initial
    begin
        i_sys_rst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 32'h0;
        i_pwdata = 32'h0;
        i_pstrb = 4'h0;
        src = 5'h00;
        n_errors = 0;
        n_tests = 0;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_sources;
        t_swrst;
        t_irq;
        t_unmapped;
        t_rerst;
        close_out;
    end
endmodule
